// File: rtl/pao_adc_port.sv
// Digital side of a ten-stage pipelined converter with a three-state result bus.
// Assumes the conversion clock, the sampled level and the control pins arrive
// asynchronously to i_clk, and that the conversion clock is far slower than i_clk.
//
// Overview of operation
// - Ten one-bit stages, advancing every clock edge.
// - Extra half cycle for error correction.
// - Code appears 5.5 conversion clocks after sampling.
// - Track from rising edge until aperture count ends, then hold.
// - Reference select high disconnects internal reference.
// - Offset binary, LSB on lowest line.
// - Full scale 1023, midscale 512, bottom 0.
// - Bus driven while enable low, else released.
// - Output updates after conversion clock falling edge.
// - Sample taken aperture delay after rising edge.
`timescale 1ns/1ps
// Widths and counts come from the shared constants header, guarded against double inclusion.
`include "pao_consts.svh"

module pao_adc_port (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_conv_clk,
  input wire logic [`PAO_BITS-1:0] i_ain_level,
  input wire logic i_oe_n,
  input wire logic i_ref_powerdown_select,
  output pao_pkg::pao_bus_s o_sample_code_bus,
  output logic o_internal_ref_on
);

  // Aperture delay in cycles, at the counter's width.
  localparam logic [`PAO_AP_CNT_W-1:0] AP_CYC = `PAO_AP_CNT_W'(`PAO_APERTURE_CYC);

  // Registered state and its next value.
  pao_pkg::pao_state_s st;
  pao_pkg::pao_state_s next_st;

  // Edges of the synchronised conversion clock.
  logic conv_rise;
  logic conv_fall;
  // Slot entering the first stage on a falling edge.
  pao_pkg::pao_stage_s load_entry;
  // Inputs and results of each stage for one advance.
  pao_pkg::pao_stage_s stage_in [`PAO_STAGES];
  pao_pkg::pao_stage_s stage_out [`PAO_STAGES];

  // Edge detection reads only the second and third flops of the clock chain.
  assign conv_rise = st.conv_s2 & ~st.conv_prev;
  assign conv_fall = ~st.conv_s2 & st.conv_prev;

  // The held sample is recoded to offset binary by inverting the sign bit.
  // offset binary coding
  always_comb begin
    load_entry.valid = conv_fall;
    load_entry.residue = {~st.track[`PAO_BITS-1], st.track[`PAO_BITS-2:0]};
    load_entry.code = `PAO_CODE_RST;
  end

  // Each stage takes the top residue bit as its result and doubles the residue.
  // one bit per stage
  genvar k;
  generate
    for (k = 0; k < `PAO_STAGES; k = k + 1) begin : g_stage
      if (k == 0) begin : g_first
        assign stage_in[k] = load_entry;
      end else begin : g_rest
        assign stage_in[k] = st.pipe[k-1];
      end
      assign stage_out[k].valid = stage_in[k].valid;
      assign stage_out[k].residue = {stage_in[k].residue[`PAO_BITS-2:0], 1'b0};
      assign stage_out[k].code = {stage_in[k].code[`PAO_BITS-2:0],
                                  stage_in[k].residue[`PAO_BITS-1]};
    end
  endgenerate

  // Next-state logic for synchronisers, sampling, pipeline and bus.
  always_comb begin
    next_st = st;
    // Two-flop synchronisers for every pin; nothing else reads the first flop.
    next_st.conv_s1 = i_conv_clk;
    next_st.conv_s2 = st.conv_s1;
    next_st.conv_prev = st.conv_s2;
    next_st.oe_s1 = i_oe_n;
    next_st.oe_s2 = st.oe_s1;
    next_st.ref_s1 = i_ref_powerdown_select;
    next_st.ref_s2 = st.ref_s1;
    next_st.ain_s1 = i_ain_level;
    next_st.ain_s2 = st.ain_s1;
    // Sampling phase machine.
    case (st.ph)
      pao_pkg::PH_IDLE: begin
        if (conv_rise) begin
          next_st.ph = pao_pkg::PH_WAIT;
          next_st.ap_cnt = AP_CYC;
        end
      end
      pao_pkg::PH_WAIT: begin
        if (st.conv_s2) begin
          next_st.track = st.ain_s2;
        end
        if (st.ap_cnt <= `PAO_AP_CNT_W'(1) || !st.conv_s2) begin
          next_st.ph = pao_pkg::PH_IDLE;
          next_st.ap_cnt = '0;
        end else begin
          next_st.ap_cnt = st.ap_cnt - `PAO_AP_CNT_W'(1);
        end
      end
      default: begin
        next_st.ph = pao_pkg::PH_IDLE;
      end
    endcase
    if (conv_rise || conv_fall) begin
      for (int i = 0; i < `PAO_STAGES; i++) begin
        next_st.pipe[i] = stage_out[i];
      end
    end
    if (conv_fall && st.pipe[`PAO_STAGES-1].valid) begin
      next_st.bus = st.pipe[`PAO_STAGES-1].code;
    end
    next_st.oe_n = st.oe_s2;
    next_st.ref_dis = st.ref_s2;
  end

  // State register; reset loads constants only.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= '0;
      st.ph <= pao_pkg::PH_IDLE;
      st.bus <= `PAO_CODE_RST;
      st.oe_n <= `PAO_OE_N_RST;
      st.ref_dis <= `PAO_REF_DIS_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops.
  assign o_sample_code_bus.code = st.bus;
  assign o_sample_code_bus.oe_n = st.oe_n;
  assign o_internal_ref_on = ~st.ref_dis;

  // A slot that sits in the first stage moves to the second stage at the next edge.
  property p_stage_advance;
    @(posedge i_clk) disable iff (!i_arst_n)
      (conv_rise || conv_fall) |=> (st.pipe[1].valid == $past(st.pipe[0].valid));
  endproperty
  a_stage_advance: assert property (p_stage_advance) else $error("stage did not advance");

  // A complete slot reaches the bus at a falling edge.
  property p_correction;
    @(posedge i_clk) disable iff (!i_arst_n)
      (conv_fall && st.pipe[`PAO_STAGES-1].valid) |=> (st.bus == $past(st.pipe[`PAO_STAGES-1].code));
  endproperty
  a_correction: assert property (p_correction) else $error("bus missed finished code");

  // The first stage resolves the top bit of the offset-binary value it loads.
  sequence s_load;
    conv_fall;
  endsequence
  property p_code_exact;
    logic [`PAO_BITS-1:0] v;
    @(posedge i_clk) disable iff (!i_arst_n)
      (s_load, v = load_entry.residue) |=> (st.pipe[0].code[0] == v[`PAO_BITS-1]);
  endproperty
  a_code_exact: assert property (p_code_exact) else $error("first stage bit wrong");

  // While high and counting, the tracked value follows the input.
  property p_track;
    @(posedge i_clk) disable iff (!i_arst_n)
      (st.ph == pao_pkg::PH_WAIT && st.conv_s2) |=> (st.track == $past(st.ain_s2));
  endproperty
  a_track: assert property (p_track) else $error("track did not follow input");

  // The reference flag is the inverse of the select pin, one flop after its synchroniser, both ways.
  property p_ref;
    @(posedge i_clk) disable iff (!i_arst_n)
      1'h1 |=> (o_internal_ref_on == !$past(st.ref_s2));
  endproperty
  a_ref: assert property (p_ref) else $error("internal reference still on");

  // Offset binary: the sign bit is inverted, the rest passes.
  property p_offset;
    @(posedge i_clk) disable iff (!i_arst_n)
      conv_fall |-> (load_entry.residue[`PAO_BITS-1] != st.track[`PAO_BITS-1]
                     && load_entry.residue[`PAO_BITS-2:0] == st.track[`PAO_BITS-2:0]);
  endproperty
  a_offset: assert property (p_offset) else $error("offset binary coding wrong");

  // The enable reaches the drivers one flop after its synchroniser, both ways.
  property p_oe;
    @(posedge i_clk) disable iff (!i_arst_n)
      1'h1 |=> (o_sample_code_bus.oe_n == $past(st.oe_s2));
  endproperty
  a_oe: assert property (p_oe) else $error("bus not released");

  // The bus only changes right after a falling edge.
  property p_fall_only;
    @(posedge i_clk) disable iff (!i_arst_n)
      !$past(conv_fall) |-> $stable(o_sample_code_bus.code);
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("bus changed off a falling edge");

  // A rising edge starts the aperture count.
  property p_aperture;
    @(posedge i_clk) disable iff (!i_arst_n)
      (conv_rise && st.ph == pao_pkg::PH_IDLE) |=> (st.ph == pao_pkg::PH_WAIT);
  endproperty
  a_aperture: assert property (p_aperture) else $error("aperture not started");

endmodule : pao_adc_port

// File: rtl/pao_consts.svh
// Named constants for the pipelined converter output port.
// Assumes it is included by its bare name from the package and the design.
`ifndef PAO_CONSTS_SVH
`define PAO_CONSTS_SVH

// Result width in bits; bit 0 is the least significant line of the bus.
`define PAO_BITS 10
// Number of one-bit pipeline stages.
`define PAO_STAGES 10
// System clock period in picoseconds (250 MHz).
`define PAO_CLK_PERIOD_PS 4000
// Aperture delay after the conversion clock rising edge, in picoseconds.
`define PAO_APERTURE_PS 1000
// Aperture delay in system cycles, a least time rounded up, never below one.
`define PAO_APERTURE_CYC \
  ((((`PAO_APERTURE_PS) + (`PAO_CLK_PERIOD_PS) - 1) / (`PAO_CLK_PERIOD_PS)) < 1 ? 1 : \
   (((`PAO_APERTURE_PS) + (`PAO_CLK_PERIOD_PS) - 1) / (`PAO_CLK_PERIOD_PS)))
// Width of the aperture counter.
`define PAO_AP_CNT_W 4
// Reset value of the active-low bus enable: bus released.
`define PAO_OE_N_RST 1'b1
// Reset value of the reference disconnect flag: internal reference in use.
`define PAO_REF_DIS_RST 1'b0
// Reset value of the output code.
`define PAO_CODE_RST 10'h000

`endif

// File: rtl/pao_pkg.sv
// Types shared by the pipelined converter output port.
// Assumes pao_consts.svh is on the include path.
`include "pao_consts.svh"

package pao_pkg;

  // Sampling phase: waiting for a rising edge, or counting the aperture.
  typedef enum logic [0:0] {
    PH_IDLE = 1'b0,
    PH_WAIT = 1'b1
  } pao_phase_e;

  // One pipeline slot: a valid flag, the remaining residue and the bits resolved so far.
  typedef struct packed {
    logic valid;
    logic [`PAO_BITS-1:0] residue;
    logic [`PAO_BITS-1:0] code;
  } pao_stage_s;

  // Output bus carrier: the code and its active-low drive enable.
  typedef struct packed {
    logic [`PAO_BITS-1:0] code;
    logic oe_n;
  } pao_bus_s;

  // Whole state of the port.
  typedef struct packed {
    logic conv_s1;
    logic conv_s2;
    logic conv_prev;
    logic oe_s1;
    logic oe_s2;
    logic ref_s1;
    logic ref_s2;
    logic [`PAO_BITS-1:0] ain_s1;
    logic [`PAO_BITS-1:0] ain_s2;
    pao_phase_e ph;
    logic [`PAO_AP_CNT_W-1:0] ap_cnt;
    logic [`PAO_BITS-1:0] track;
    pao_stage_s [`PAO_STAGES-1:0] pipe;
    logic [`PAO_BITS-1:0] bus;
    logic oe_n;
    logic ref_dis;
  } pao_state_s;

endpackage : pao_pkg

// File: verif/pao_capture_model.sv
// Capture logic that latches the resolved result bus.
// Assumes the bench resolves the bus wire and runs the conversion clock.
`timescale 1ns/1ps
`include "pao_consts.svh"

module pao_capture_model (
  input wire logic i_conv_clk,
  input wire logic [`PAO_BITS-1:0] i_sample_code_bus,
  output logic [`PAO_BITS-1:0] o_captured
);
  // latch after fall
  // Latch half a period after the falling edge, so the new code has settled.
  always_ff @(posedge i_conv_clk) begin
    o_captured <= i_sample_code_bus;
  end
endmodule : pao_capture_model

// File: verif/testbench.sv
// Self-checking bench for the converter output port.
// Assumes pao_consts.svh and pao_pkg are compiled first.
`timescale 1ns/1ps
`include "pao_consts.svh"

module testbench;
  localparam int HALF = 8; // Conversion clock half period in i_clk cycles.
  localparam int NPER = 40; // Conversion periods in the run.
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_conv_clk = 1'b0;
  logic [`PAO_BITS-1:0] i_ain_level = 10'h000;
  logic i_oe_n = 1'b0;
  logic i_ref_powerdown_select = 1'b0;
  pao_pkg::pao_bus_s o_sample_code_bus; // Result bus carrier.
  logic o_internal_ref_on; // Internal reference flag.
  logic [`PAO_BITS-1:0] last_code = 10'h000; // Last driven code.
  logic [`PAO_BITS-1:0] bus_wire; // Resolved bus level.
  logic [`PAO_BITS-1:0] cap; // Code held by the capture model.
  logic [`PAO_BITS-1:0] vals [NPER]; // Sampled levels per period.
  logic oe_seq [NPER]; // Bus enable per period.
  int num_errors = 0;
  int checked = 0;
  int seed = 99532;

  pao_adc_port pao_adc_port_inst (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_conv_clk(i_conv_clk),
    .i_ain_level(i_ain_level),
    .i_oe_n(i_oe_n),
    .i_ref_powerdown_select(i_ref_powerdown_select),
    .o_sample_code_bus(o_sample_code_bus),
    .o_internal_ref_on(o_internal_ref_on)
  );

  pao_capture_model pao_capture_model_inst (
    .i_conv_clk(i_conv_clk),
    .i_sample_code_bus(bus_wire),
    .o_captured(cap)
  );

  // A released bus shows the inverse of its last value, never a kind guess.
  always @(posedge i_clk) begin
    if (o_sample_code_bus.oe_n === 1'b0) last_code <= o_sample_code_bus.code;
  end
  assign bus_wire = o_sample_code_bus.oe_n ? ~last_code : o_sample_code_bus.code;

  // System clock, 4 ns period.
  initial begin
    forever #2 i_clk = ~i_clk;
  end

  // Offset binary is the level with its top bit inverted.
  function automatic logic [`PAO_BITS-1:0] exp_code(input logic [`PAO_BITS-1:0] v);
    return v ^ 10'h200;
  endfunction : exp_code

  // Corner levels: top, zero, minus one and bottom.
  function automatic logic [`PAO_BITS-1:0] corner(input int n);
    case (n)
      0: return 10'h1FF;
      1: return 10'h000;
      2: return 10'h3FF;
      default: return 10'h200;
    endcase
  endfunction : corner

  // Compares a code.
  task automatic check_code(input logic [`PAO_BITS-1:0] want, input logic [`PAO_BITS-1:0] got);
    checked++;
    if (got !== want) begin
      num_errors++;
      $display("FAIL t=%0t want=%h got=%h", $time, want, got);
    end
  endtask : check_code

  // Compares a single flag.
  task automatic check_bit(input logic want, input logic got);
    checked++;
    if (got !== want) begin
      num_errors++;
      $display("FAIL t=%0t want=%h got=%h", $time, want, got);
    end
  endtask : check_bit

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict;
    $display("Counts: checked=%0d errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  // Cuts a hang short: twice the planned run in ns, with slack for reset.
  initial begin
    #(8 * (NPER * 2 * HALF + 16));
    num_errors++;
    print_verdict();
  end

  // Main sequence: one conversion period per pass, corners first, then random.
  initial begin
    repeat (8) @(posedge i_clk);
    #1 i_arst_n = 1'b1;
    for (int n = 0; n < NPER; n++) begin
      vals[n] = (n < 4) ? corner(n) : `PAO_BITS'($random(seed));
      oe_seq[n] = (n % 7 == 5);
      i_ain_level = vals[n];
      i_oe_n = oe_seq[n];
      i_ref_powerdown_select = n[2];
      repeat (HALF) @(posedge i_clk);
      #1 i_conv_clk = 1'b1;
      @(posedge i_clk);
      #1;
      check_bit(~n[2], o_internal_ref_on);
      check_bit(oe_seq[n], o_sample_code_bus.oe_n);
      if (n >= 6 && !oe_seq[n]) begin
        check_code(exp_code(vals[n-6]), cap);
      end
      repeat (6) @(posedge i_clk);
      #1 i_ain_level = ~vals[n];
      @(posedge i_clk);
      #1 i_conv_clk = 1'b0;
    end
    print_verdict();
  end
endmodule : testbench
